// [dv/can_bus_partner.sv]
`timescale 1ns/10ps
`default_nettype none
// transceiver plus other nodes: wired bus seen back on the receive pin
module can_bus_partner (
	input  wire logic ref_clk,
	input  wire logic txPin,
	input  wire logic othersDominant,
	input  wire logic slow,
	output logic      rxPin
);
	logic [2:0] pipe = 3'h7; // loop delay line, idle bus is recessive
	logic       busLevel;    // resolved bus level
	// dominant from any node wins the bus
	assign busLevel = txPin & !othersDominant;
	// slow mode models a long cable loop delay
	always @(posedge ref_clk) pipe <= {pipe[1:0], busLevel};
	assign rxPin = slow ? pipe[2] : pipe[0];
endmodule : can_bus_partner
`default_nettype wire

// [dv/can_controller_control_status_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module can_controller_control_status_tb;
	import can_ctl_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	wb_req_type wbReq = '0;
	engine_status_type engSt = '{txBit:1'b1, default:'0}; // idle engine sends recessive
	engine_ctrl_type engineCtrl;
	logic waitMode = 1'b0, othersDom = 1'b0, slow = 1'b0;
	logic wbAck, busReceivePin, busTransmitPin, busIfClockRun, stampWrite;
	logic [31:0] wbDat, rnd;
	logic [15:0] stampValue;
	logic [7:0] stampHighByte, stampLowByte;
	logic [63:0] expQ[$], note; // expected read value and mask
	int errTotal = 0, checked = 0, cycles = 0, seed = 32'hC02A8535;
	always #5 ref_clk = ~ref_clk;
	can_controller_control_status can_controller_control_status_i (.ref_clk(ref_clk), .rst(rst),
		.wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat), .busReceivePin(busReceivePin),
		.busTransmitPin(busTransmitPin), .engineStatus(engSt), .engineCtrl(engineCtrl),
		.waitMode(waitMode), .busIfClockRun(busIfClockRun), .stampWrite(stampWrite),
		.stampValue(stampValue), .stampHighByte(stampHighByte), .stampLowByte(stampLowByte));
	can_bus_partner can_bus_partner_i (.ref_clk(ref_clk), .txPin(busTransmitPin),
		.othersDominant(othersDom), .slow(slow), .rxPin(busReceivePin));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// one classic cycle; mask zero means nothing to compare
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		expQ.push_back({e, m});
		wbReq <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hF, dat:d};
		do @(posedge ref_clk); while (wbAck !== 1'b1);
		wbReq <= '0;
		@(posedge ref_clk);
	endtask : bus
	task automatic stopTest();
		$display("compared %0d, mismatched %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stopTest
	// result watcher: every ack retires the oldest note
	always @(posedge ref_clk) if (wbAck === 1'b1 && expQ.size() > 0) begin
		note = expQ.pop_front();
		if (note[31:0] != 0) check(wbDat & note[31:0], note[63:32]);
	end
	// hang guard, a normal run needs about 1400 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles >= 20000) begin
			errTotal++;
			stopTest();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h01, 32'hFF);
		rnd = ($random(seed) | 32'h1) & 32'hFFFFFFFD; // no sleep request left over
		bus(1, ADDR_CONTROL_ZERO, rnd, 0, 0);
		bus(0, ADDR_CONTROL_ZERO, 0, rnd & 32'h07, 32'hFF);
		bus(0, ADDR_TIMER, 0, 0, 32'hFFFF);
		$display("test init done");
		bus(1, ADDR_CONTROL_ZERO, 32'h00, 0, 0);
		bus(1, ADDR_CONTROL_ZERO, 32'h2C, 0, 0);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h2C, 32'hAF);
		for (int i = 0; i < 3000 && engineCtrl.synced !== 1'b1; i++) @(posedge ref_clk);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h10, 32'h10);
		engSt.txBit <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(busTransmitPin, 0);
		waitMode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check({busIfClockRun, busTransmitPin}, 32'h1);
		waitMode <= 1'b0;
		engSt.txBit <= 1'b1;
		$display("test pin done");
		engSt.frameValid <= 1'b1;
		@(posedge ref_clk);
		engSt.frameValid <= 1'b0;
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h80, 32'h80);
		bus(1, ADDR_CONTROL_ZERO, 32'h2C, 0, 0);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h80, 32'h80);
		bus(1, ADDR_CONTROL_ZERO, 32'hAC, 0, 0);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h00, 32'h80);
		engSt.rxActive <= 1'b1;
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h40, 32'h40);
		engSt.rxActive <= 1'b0;
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h00, 32'h40);
		$display("test flags done");
		for (int k = 0; k < 2; k++) begin
			engSt.frameAcked <= 1'b1;
			@(posedge ref_clk);
			engSt.frameAcked <= 1'b0;
			@(negedge ref_clk);
			check({stampWrite, stampHighByte, stampLowByte}, {!k[0], 16'h0E0F});
			check(stampValue == 16'h0000, k[0]);
			@(posedge ref_clk);
			bus(1, ADDR_CONTROL_ZERO, 32'h24, 0, 0);
		end
		bus(0, ADDR_TIMER, 0, 0, 32'hFFFF);
		$display("test stamp done");
		engSt.txPending <= 1'b1;
		bus(1, ADDR_CONTROL_ZERO, 32'h26, 0, 0);
		repeat (20) @(posedge ref_clk);
		check(engineCtrl.sleepMode, 0);
		engSt.txPending <= 1'b0;
		for (int i = 0; i < 50 && engineCtrl.sleepMode !== 1'b1; i++) @(posedge ref_clk);
		bus(0, ADDR_MODE_CONFIG, 0, 32'h02, 32'h02);
		othersDom <= 1'b1;
		repeat (10) @(posedge ref_clk);
		othersDom <= 1'b0;
		repeat (10) @(posedge ref_clk);
		check(engineCtrl.sleepMode, 1);
		slow <= 1'b1;
		othersDom <= 1'b1;
		repeat (80) @(posedge ref_clk);
		othersDom <= 1'b0;
		repeat (10) @(posedge ref_clk);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h04, 32'h06);
		$display("test sleep done");
		bus(1, 8'h3C, rnd, 0, 0);
		bus(0, 8'h3C, 0, 0, 32'hFFFFFFFF);
		bus(1, ADDR_CONTROL_ZERO, 32'h05, 0, 0);
		bus(0, ADDR_CONTROL_ZERO, 0, 32'h05, 32'hFF);
		bus(0, ADDR_MODE_CONFIG, 0, 32'h01, 32'h01);
		$display("test reinit done");
		bus(1, ADDR_MODE_CONFIG, 32'h5C, 0, 0);
		bus(0, ADDR_MODE_CONFIG, 0, 32'hDD, 32'hFF);
		bus(1, ADDR_BIT_PERIOD, 32'hC8, 0, 0);
		bus(0, ADDR_BIT_PERIOD, 0, 32'hC8, 32'hFFFF);
		engSt.txBit <= 1'b0;
		@(posedge ref_clk);
		check({engineCtrl.clockSource, engineCtrl.rxBit, busTransmitPin, engineCtrl.filterMode}, 32'h16);
		engSt.rxErrState <= 2'h1;
		@(posedge ref_clk);
		bus(0, ADDR_ERROR_STATUS, 0, 32'h11, 32'hFF);
		bus(1, ADDR_ERROR_STATUS, 32'hF0, 0, 0);
		bus(0, ADDR_ERROR_STATUS, 0, 32'h01, 32'hFF);
		$display("test config done");
		stopTest();
	end
endmodule : can_controller_control_status_tb
bind can_controller_control_status can_ctl_sva can_ctl_sva_i (.ref_clk(ref_clk), .rst(rst),
	.wbReq(wbReq), .wbAck(wbAck), .busTransmitPin(busTransmitPin),
	.engineStatus(engineStatus), .engineCtrl(engineCtrl), .waitMode(waitMode),
	.busIfClockRun(busIfClockRun), .stampWrite(stampWrite));
`default_nettype wire

// [dv/can_ctl_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the control and status block
module can_ctl_sva
	import can_ctl_pkg::*;
(
	input wire logic                              ref_clk,
	input wire logic                              rst,
	input wire can_ctl_pkg::wb_req_type           wbReq,
	input wire logic                              wbAck,
	input wire logic                              busTransmitPin,
	input wire can_ctl_pkg::engine_status_type    engineStatus,
	input wire can_ctl_pkg::engine_ctrl_type      engineCtrl,
	input wire logic                              waitMode,
	input wire logic                              busIfClockRun,
	input wire logic                              stampWrite
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// a request not yet answered
	sequence s_req; wbReq.cyc && wbReq.stb && !wbAck; endsequence
	// ack stands exactly one cycle
	sequence s_ack; wbAck ##1 !wbAck; endsequence
	// gate held two cycles, so the registered pin has caught up
	sequence s_gated; (waitMode && !busIfClockRun) [*2]; endsequence
	property p_ack_next; s_req |=> s_ack; endproperty
	property p_init_recessive; engineCtrl.initMode |-> busTransmitPin; endproperty
	property p_wait_gate; !busIfClockRun |-> waitMode; endproperty
	property p_wait_recessive; s_gated |-> busTransmitPin; endproperty
	property p_stamp_cause; stampWrite |-> $past(engineStatus.frameAcked); endproperty
	// first init cycle may still carry a stamp launched before entry
	property p_stamp_init;
		engineCtrl.initMode && $past(engineCtrl.initMode) |-> !stampWrite;
	endproperty
	property p_sync_init; engineCtrl.synced |-> !engineCtrl.initMode; endproperty
	property p_sleep_idle;
		$rose(engineCtrl.sleepMode) |-> !$past(engineStatus.txPending);
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("bus ack not one cycle after request");
	a_init_recessive: assert property (p_init_recessive)
		else $error("transmit pin dominant in init");
	a_wait_gate: assert property (p_wait_gate)
		else $error("clock stopped outside wait");
	a_wait_recessive: assert property (p_wait_recessive)
		else $error("transmit pin dominant while clock stopped");
	a_stamp_cause: assert property (p_stamp_cause)
		else $error("stamp write without acknowledge");
	a_stamp_init: assert property (p_stamp_init)
		else $error("stamp write in init");
	a_sync_init: assert property (p_sync_init)
		else $error("synced while in init");
	a_sleep_idle: assert property (p_sleep_idle)
		else $error("sleep entered with pending transmit");
endmodule : can_ctl_sva
`default_nettype wire

// [rtl/can_controller_control_status.sv]
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - transmit pin low dominant, high recessive
// - standard, extended, remote frames, up to eight bytes
// - programmable bit rate, at most 1 Mbps
// - five receive buffers as a FIFO
// - three transmit buffers, local priority choice
// - filters as 2x32, 4x16 or 8x8 bits
// - software picks bus or oscillator clock
// - loopback self test and listen-only modes
// - flag every receive/transmit error state change
// - enabled bus-activity wakeup with glitch filter
// - init mode holds the stop, timer and frame bits of control_zero at reset values
// - writes outside init; status bits read-only
// - frame flag hardware set, write one clears
// - receiver active shows ongoing reception
// - stop bus interface clocks in wait
// - synced flag while able to communicate
// - 16-bit bit-rate timer, zeroed when disabled
// - time stamp stored on acknowledge
// - wakeup enable set before sleep request
// - init request aborts, acknowledged, then clearable
// - sleep only when idle, acknowledged by flag; while seeking sync only a pending transmit is checked
// - resync after 11 recessive, 128 in bus-off
module can_controller_control_status
	import can_ctl_pkg::*;
#(
	parameter int RX_BUFFERS = RX_BUFFER_COUNT, // receive queue depth for the store
	parameter int TX_BUFFERS = TX_BUFFER_COUNT  // transmit slots for the store
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire can_ctl_pkg::wb_req_type  wbReq,
	output logic                          wbAck,
	output logic [31:0]                   wbDat,
	input  wire logic                     busReceivePin,
	output logic                          busTransmitPin,
	input  wire can_ctl_pkg::engine_status_type engineStatus,
	output can_ctl_pkg::engine_ctrl_type  engineCtrl,
	input  wire logic                     waitMode,
	output logic                          busIfClockRun,
	output logic                          stampWrite,
	output logic [15:0]                   stampValue,
	output logic [7:0]                    stampHighByte,
	output logic [7:0]                    stampLowByte
);
	import can_ctl_pkg::*;

	typedef enum logic [3:0] {
		ST_INIT  = 4'b0001,
		ST_SEEK  = 4'b0010,
		ST_RUN   = 4'b0100,
		ST_SLEEP = 4'b1000
	} mode_state_type;

	mode_state_type state;          // protocol mode
	mode_state_type next_state;     // mode for the next cycle
	logic [7:0]     controlZero;    // stored bits of control_zero
	logic           loopback;       // internal self test
	logic           listenOnly;     // monitor only, never drives
	logic           clockSource;    // 1 selects oscillator clock
	logic [1:0]     filterMode;     // acceptance filter layout
	logic           wakeFlag;       // traffic woke the block
	logic [15:0]    bitPeriod;      // cycles of ref_clk per bit
	logic [15:0]    bitCount;       // position inside a bit
	logic           bitTick;        // one pulse per bit time
	logic [15:0]    timer;          // time stamp timer
	logic [7:0]     runsSeen;       // idle runs since seeking
	logic [3:0]     errPrev;        // last error states seen
	logic [3:0]     errChanged;     // sticky change flags
	logic           rxBit;          // synchronised receive level
	logic           wakeDominant;   // filtered bus traffic
	logic           idleRun;        // eleven recessive bits seen
	logic           busRequest;     // a bus cycle is open
	logic           commit;         // write takes effect this edge
	logic [31:0]    readWord;       // read data to be registered
	logic           initAck;        // init mode entered
	logic           sleepAck;       // sleep mode entered
	logic           inInit;         // request and ack both high
	logic           outOfInit;      // request and ack both low
	logic [15:0]    periodUsed;     // period after the rate clamp
	logic           initHold;       // init entered now or already active
	logic [3:0]     errNow;         // error states this cycle

	// true when the bus writes the low byte at the given offset
	function automatic logic lowByteWrite(input logic [7:0] offset);
		lowByteWrite = commit && wbReq.we && wbReq.sel[0] && wbReq.adr == offset;
	endfunction : lowByteWrite

	assign initAck    = (state == ST_INIT);
	assign sleepAck   = (state == ST_SLEEP);
	assign inInit     = controlZero[BIT_INIT_REQ] && initAck;
	assign outOfInit  = !controlZero[BIT_INIT_REQ] && !initAck;
	// cleared on the entry edge, so the first init cycle already reads reset values
	assign initHold   = controlZero[BIT_INIT_REQ] && (next_state == ST_INIT);
	assign errNow     = {engineStatus.txErrState, engineStatus.rxErrState};
	assign busRequest = wbReq.cyc && wbReq.stb;
	assign commit     = busRequest && wbAck;

	// receive front end: synchroniser, wake filter, idle run detector
	can_rx_front u_rx_front (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.rxPin        (busReceivePin),
		.bitTick      (bitTick),
		.rxBit        (rxBit),
		.wakeDominant (wakeDominant),
		.idleRun      (idleRun)
	);

	// wishbone answer: one wait cycle, ack dropped the cycle after it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wbAck <= 1'b0;
			wbDat <= 32'h0000_0000;
		end else begin
			wbAck <= busRequest && !wbAck;
			if (busRequest && !wbAck) begin
				wbDat <= readWord;
			end
		end
	end

	// read mux; unmapped offsets read as zero and ignore writes
	always_comb begin
		readWord = 32'h0000_0000;
		case (wbReq.adr)
			ADDR_CONTROL_ZERO: begin
				readWord[7:0]              = controlZero;
				readWord[BIT_RX_ACTIVE]    = engineStatus.rxActive;
				readWord[BIT_SYNCED]       = (state == ST_RUN);
			end
			ADDR_MODE_CONFIG: begin
				readWord[BIT_INIT_ACK]     = initAck;
				readWord[BIT_SLEEP_ACK]    = sleepAck;
				readWord[BIT_LOOPBACK]     = loopback;
				readWord[BIT_LISTEN_ONLY]  = listenOnly;
				readWord[BIT_CLOCK_SRC]    = clockSource;
				readWord[BIT_FILTER_LO+:2] = filterMode;
				readWord[BIT_WAKE_FLAG]    = wakeFlag;
			end
			ADDR_BIT_PERIOD: begin
				readWord[15:0] = bitPeriod;
			end
			ADDR_ERROR_STATUS: begin
				readWord[3:0]                = errPrev;
				readWord[ERR_CHANGE_LO+:4]   = errChanged;
			end
			ADDR_TIMER: begin
				readWord[15:0] = timer;
			end
			default: begin
				readWord = 32'h0000_0000;
			end
		endcase
	end

	// mode machine: init, seeking sync, running, sleeping
	always_comb begin
		next_state = state;
		case (state)
			ST_INIT: begin
				if (!controlZero[BIT_INIT_REQ]) begin
					next_state = ST_SEEK;
				end
			end
			ST_SEEK: begin
				if (controlZero[BIT_INIT_REQ]) begin
					next_state = ST_INIT;
				end else if (controlZero[BIT_SLEEP_REQ] && !engineStatus.txPending) begin
					next_state = ST_SLEEP;
				end else if (idleRun && (!engineStatus.busOff ||
						runsSeen == 8'(BUS_OFF_RUNS - 1))) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (controlZero[BIT_INIT_REQ]) begin
					next_state = ST_INIT;
				end else if (controlZero[BIT_SLEEP_REQ] && !engineStatus.rxActive &&
						!engineStatus.txPending) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (controlZero[BIT_INIT_REQ]) begin
					next_state = ST_INIT;
				end else if (!controlZero[BIT_SLEEP_REQ]) begin
					next_state = ST_SEEK; // sync is rebuilt after sleep
				end
			end
			default: begin
				next_state = ST_INIT;
			end
		endcase
	end

	// the block comes out of reset in init mode, like a cold start
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	// idle runs counted while seeking; bus-off needs many of them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			runsSeen <= 8'h00;
		end else if (state != ST_SEEK) begin
			runsSeen <= 8'h00;
		end else if (idleRun) begin
			runsSeen <= runsSeen + 8'h01;
		end
	end

	// request bits: init and sleep can only be withdrawn once acked
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			controlZero[BIT_INIT_REQ]  <= CONTROL_ZERO_RESET[BIT_INIT_REQ];
			controlZero[BIT_SLEEP_REQ] <= CONTROL_ZERO_RESET[BIT_SLEEP_REQ];
			controlZero[BIT_WAKEUP_EN] <= CONTROL_ZERO_RESET[BIT_WAKEUP_EN];
		end else begin
			if (lowByteWrite(ADDR_CONTROL_ZERO)) begin
				// writable in every mode
				controlZero[BIT_WAKEUP_EN] <= wbReq.dat[BIT_WAKEUP_EN];
				if (wbReq.dat[BIT_INIT_REQ]) begin
					controlZero[BIT_INIT_REQ] <= 1'b1;
				end else if (initAck) begin
					controlZero[BIT_INIT_REQ] <= 1'b0;
				end
			end
			if (sleepAck && controlZero[BIT_WAKEUP_EN] && wakeDominant) begin
				// traffic wins over any write in the same cycle
				controlZero[BIT_SLEEP_REQ] <= 1'b0;
			end else if (lowByteWrite(ADDR_CONTROL_ZERO)) begin
				if (wbReq.dat[BIT_SLEEP_REQ] && !wakeFlag) begin
					controlZero[BIT_SLEEP_REQ] <= 1'b1;
				end else if (!wbReq.dat[BIT_SLEEP_REQ] && sleepAck) begin
					controlZero[BIT_SLEEP_REQ] <= 1'b0;
				end
			end
		end
	end

	// ordinary bits: held at reset value in init, written only outside it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			controlZero[BIT_STOP_WAIT] <= CONTROL_ZERO_RESET[BIT_STOP_WAIT];
			controlZero[BIT_TIMER_EN]  <= CONTROL_ZERO_RESET[BIT_TIMER_EN];
		end else if (initHold) begin
			controlZero[BIT_STOP_WAIT] <= CONTROL_ZERO_RESET[BIT_STOP_WAIT];
			controlZero[BIT_TIMER_EN]  <= CONTROL_ZERO_RESET[BIT_TIMER_EN];
		end else if (outOfInit && lowByteWrite(ADDR_CONTROL_ZERO)) begin
			controlZero[BIT_STOP_WAIT] <= wbReq.dat[BIT_STOP_WAIT];
			controlZero[BIT_TIMER_EN]  <= wbReq.dat[BIT_TIMER_EN];
		end
	end

	// received-frame flag: hardware sets, write one clears, set wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			controlZero[BIT_RX_FRAME] <= CONTROL_ZERO_RESET[BIT_RX_FRAME];
		end else if (initHold) begin
			controlZero[BIT_RX_FRAME] <= CONTROL_ZERO_RESET[BIT_RX_FRAME];
		end else if (engineStatus.frameValid) begin
			// any frame format and length counts
			controlZero[BIT_RX_FRAME] <= 1'b1;
		end else if (outOfInit && lowByteWrite(ADDR_CONTROL_ZERO) &&
				wbReq.dat[BIT_RX_FRAME]) begin
			controlZero[BIT_RX_FRAME] <= 1'b0;
		end
	end

	// live status bits are never stored; the read mux shows them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			controlZero[BIT_RX_ACTIVE] <= 1'b0;
			controlZero[BIT_SYNCED]    <= 1'b0;
		end else begin
			controlZero[BIT_RX_ACTIVE] <= 1'b0;
			controlZero[BIT_SYNCED]    <= 1'b0;
		end
	end

	// wake flag: set by filtered traffic in sleep, write one clears
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wakeFlag <= 1'b0;
		end else if (sleepAck && controlZero[BIT_WAKEUP_EN] && wakeDominant) begin
			wakeFlag <= 1'b1;
		end else if (lowByteWrite(ADDR_MODE_CONFIG) && wbReq.dat[BIT_WAKE_FLAG]) begin
			wakeFlag <= 1'b0;
		end
	end

	// mode configuration is only accepted in init mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			loopback    <= 1'b0;
			listenOnly  <= 1'b0;
			clockSource <= 1'b0;
			filterMode  <= FILTER_2X32;
			bitPeriod   <= BIT_PERIOD_RESET;
		end else if (inInit) begin
			if (lowByteWrite(ADDR_MODE_CONFIG)) begin
				loopback    <= wbReq.dat[BIT_LOOPBACK];
				listenOnly  <= wbReq.dat[BIT_LISTEN_ONLY];
				clockSource <= wbReq.dat[BIT_CLOCK_SRC];
				filterMode  <= wbReq.dat[BIT_FILTER_LO+:2];
			end
			if (lowByteWrite(ADDR_BIT_PERIOD) && wbReq.sel[1]) begin
				bitPeriod <= wbReq.dat[15:0];
			end
		end
	end

	// periods shorter than the top rate are stretched to it
	assign periodUsed = (bitPeriod < 16'(MIN_BIT_CYC)) ? 16'(MIN_BIT_CYC) : bitPeriod;

	// bit clock divider; stopped in init so the timer cannot advance
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bitCount <= 16'h0000;
			bitTick  <= 1'b0;
		end else if (initAck) begin
			bitCount <= 16'h0000;
			bitTick  <= 1'b0;
		end else if (bitCount >= periodUsed - 16'h0001) begin
			bitCount <= 16'h0000;
			bitTick  <= 1'b1;
		end else begin
			bitCount <= bitCount + 16'h0001;
			bitTick  <= 1'b0;
		end
	end

	// free running stamp timer, zero whenever disabled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer <= 16'h0000;
		end else if (!controlZero[BIT_TIMER_EN]) begin
			timer <= 16'h0000;
		end else if (bitTick) begin
			timer <= timer + 16'h0001;
		end
	end

	// time stamp handed to the buffer store once a frame is acknowledged
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stampWrite <= 1'b0;
			stampValue <= 16'h0000;
		end else begin
			stampWrite <= engineStatus.frameAcked && controlZero[BIT_TIMER_EN];
			if (engineStatus.frameAcked) begin
				stampValue <= timer;
			end
		end
	end

	assign stampHighByte = STAMP_HIGH_BYTE;
	assign stampLowByte  = STAMP_LOW_BYTE;

	// error state changes are kept until software writes one to clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			errPrev    <= 4'h0;
			errChanged <= 4'h0;
		end else begin
			errPrev <= errNow;
			for (int i = 0; i < 4; i++) begin
				if (errPrev[i] != errNow[i]) begin
					errChanged[i] <= 1'b1;
				end else if (lowByteWrite(ADDR_ERROR_STATUS) &&
						wbReq.dat[ERR_CHANGE_LO + i]) begin
					errChanged[i] <= 1'b0;
				end
			end
		end
	end

	// transmit pin: the engine's bit, or recessive whenever it must not drive
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busTransmitPin <= LEVEL_RECESSIVE;
		end else if (controlZero[BIT_INIT_REQ] || sleepAck || loopback || listenOnly ||
				(waitMode && controlZero[BIT_STOP_WAIT])) begin
			busTransmitPin <= LEVEL_RECESSIVE;
		end else begin
			busTransmitPin <= engineStatus.txBit;
		end
	end

	// wait-mode gating of the processor-side clocks
	assign busIfClockRun = !(waitMode && controlZero[BIT_STOP_WAIT]);

	// control bundle for the protocol engine, buffers and filters
	always_comb begin
		engineCtrl             = '0;
		engineCtrl.initMode    = initAck;
		engineCtrl.sleepMode   = sleepAck;
		engineCtrl.synced      = (state == ST_RUN);
		engineCtrl.loopback    = loopback;
		engineCtrl.listenOnly  = listenOnly;
		engineCtrl.clockSource = clockSource;
		engineCtrl.filterMode  = filter_mode_type'(filterMode);
		// loopback feeds the engine its own bit instead of the pin
		engineCtrl.rxBit       = loopback ? engineStatus.txBit : rxBit;
		engineCtrl.bitTick     = bitTick;
	end
endmodule : can_controller_control_status
`default_nettype wire

// [rtl/can_ctl_pkg.sv]
package can_ctl_pkg;
	// protocol capability figures
	localparam int MAX_PAYLOAD_BYTES = 8;
	localparam int RX_BUFFER_COUNT   = 5;
	localparam int TX_BUFFER_COUNT   = 3;
	// clock and bit timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int MIN_BIT_NS     = 1000;
	localparam int MIN_BIT_CYC    = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_FILTER_NS = 500;
	localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_RUN_BITS  = 11;
	localparam int BUS_OFF_RUNS   = 128;
	// register byte offsets
	localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] ADDR_MODE_CONFIG  = 8'h04;
	localparam logic [7:0] ADDR_BIT_PERIOD   = 8'h08;
	localparam logic [7:0] ADDR_ERROR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_TIMER        = 8'h10;
	// control_zero bit positions
	localparam int BIT_RX_FRAME  = 7;
	localparam int BIT_RX_ACTIVE = 6;
	localparam int BIT_STOP_WAIT = 5;
	localparam int BIT_SYNCED    = 4;
	localparam int BIT_TIMER_EN  = 3;
	localparam int BIT_WAKEUP_EN = 2;
	localparam int BIT_SLEEP_REQ = 1;
	localparam int BIT_INIT_REQ  = 0;
	localparam logic [7:0] CONTROL_ZERO_RESET = 8'h01;
	// mode_config bit positions
	localparam int BIT_INIT_ACK    = 0;
	localparam int BIT_SLEEP_ACK   = 1;
	localparam int BIT_LOOPBACK    = 2;
	localparam int BIT_LISTEN_ONLY = 3;
	localparam int BIT_CLOCK_SRC   = 4;
	localparam int BIT_FILTER_LO   = 5;
	localparam int BIT_WAKE_FLAG   = 7;
	localparam int ERR_CHANGE_LO   = 4;
	localparam logic [15:0] BIT_PERIOD_RESET = 16'h0064;
	// time stamp lands in the two top bytes of the active buffer
	localparam logic [7:0] STAMP_HIGH_BYTE = 8'h0E;
	localparam logic [7:0] STAMP_LOW_BYTE  = 8'h0F;
	// bus pin levels
	localparam logic LEVEL_DOMINANT  = 1'b0;
	localparam logic LEVEL_RECESSIVE = 1'b1;

	typedef enum logic [1:0] {
		FILTER_2X32 = 2'h0,
		FILTER_4X16 = 2'h1,
		FILTER_8X8  = 2'h2,
		FILTER_OFF  = 2'h3
	} filter_mode_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	typedef struct packed {
		logic       frameValid;
		logic       frameAcked;
		logic       rxActive;
		logic       txBit;
		logic       txPending;
		logic       busOff;
		logic [1:0] rxErrState;
		logic [1:0] txErrState;
	} engine_status_type;

	typedef struct packed {
		logic            initMode;
		logic            sleepMode;
		logic            synced;
		logic            loopback;
		logic            listenOnly;
		logic            clockSource;
		filter_mode_type filterMode;
		logic            rxBit;
		logic            bitTick;
	} engine_ctrl_type;
endpackage : can_ctl_pkg

// [rtl/can_rx_front.sv]
`timescale 1ns/10ps
`default_nettype none
module can_rx_front
	import can_ctl_pkg::*;
#(
	parameter int FILTER_CYC = WAKE_FILTER_CYC,
	parameter int RUN_BITS   = IDLE_RUN_BITS
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic rxPin,
	input  wire logic bitTick,
	output logic      rxBit,
	output logic      wakeDominant,
	output logic      idleRun
);
	logic       syncFirst;   // first stage, read only by syncSecond
	logic       syncSecond;  // safe copy of the pin
	logic [7:0] lowCount;    // dominant run length for the wake filter
	logic [3:0] runCount;    // consecutive recessive bit samples

	// two-stage synchroniser; the pin is asynchronous to ref_clk
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			syncFirst  <= LEVEL_RECESSIVE;
			syncSecond <= LEVEL_RECESSIVE;
		end else begin
			syncFirst  <= rxPin;
			syncSecond <= syncFirst;
		end
	end

	assign rxBit = syncSecond;

	// low-pass: only a dominant level held long enough counts as traffic
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lowCount     <= 8'h00;
			wakeDominant <= 1'b0;
		end else if (syncSecond == LEVEL_RECESSIVE) begin
			lowCount     <= 8'h00;
			wakeDominant <= 1'b0;
		end else if (lowCount == 8'(FILTER_CYC - 1)) begin
			wakeDominant <= 1'b1;
		end else begin
			lowCount <= lowCount + 8'h01;
		end
	end

	// count recessive bit samples; a dominant bit restarts the run
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			runCount <= 4'h0;
			idleRun  <= 1'b0;
		end else begin
			idleRun <= 1'b0;
			if (bitTick) begin
				if (syncSecond == LEVEL_DOMINANT) begin
					runCount <= 4'h0;
				end else if (runCount == 4'(RUN_BITS - 1)) begin
					runCount <= 4'h0;
					idleRun  <= 1'b1;
				end else begin
					runCount <= runCount + 4'h1;
				end
			end
		end
	end
endmodule : can_rx_front
`default_nettype wire
